// ### rtw_defines.vh
`ifndef RTW_DEFINES_VH
`define RTW_DEFINES_VH
// clock and timing
`define RTW_CLK_MHZ        200
`define RTW_CLK_NS         5
`define RTW_RST_LIMIT_US   5000
`define RTW_ST_LIMIT_US    100000
`define RTW_RST_US         1000
`define RTW_ST_US          50000
`define RTW_RTRT_NS        57000
`define RTW_RTRT_CYC       (`RTW_RTRT_NS / `RTW_CLK_NS)
// command word fields
`define RTW_CMD_ADDR_HI    15
`define RTW_CMD_ADDR_LO    11
`define RTW_CMD_TR         10
`define RTW_CMD_SA_HI      9
`define RTW_CMD_SA_LO      5
`define RTW_CMD_WC_HI      4
`define RTW_CMD_WC_LO      0
// reserved addresses and subaddresses
`define RTW_BCAST_ADDR     5'h1F
`define RTW_MODE_SA0       5'h00
`define RTW_MODE_SA1       5'h1F
`define RTW_WRAP_SA        5'h1E
// mode codes
`define RTW_MC_TX_STATUS   5'h02
`define RTW_MC_SELF_TEST   5'h03
`define RTW_MC_SHUTDOWN    5'h04
`define RTW_MC_OVERRIDE    5'h05
`define RTW_MC_RESET       5'h08
// status word bit positions
`define RTW_ST_ME          10
`define RTW_ST_SR          8
`define RTW_ST_BCR         4
`define RTW_ST_BUSY        3
`define RTW_ST_SSF         2
`define RTW_ST_TF          0
// register byte addresses
`define RTW_REG_CTRL       12'h000
`define RTW_REG_STAT       12'h004
`define RTW_REG_LASTCMD    12'h008
// control register fields and reset value
`define RTW_CTRL_SR        0
`define RTW_CTRL_SSF       1
`define RTW_CTRL_FAULT     2
`define RTW_CTRL_BCAST     3
`define RTW_CTRL_STEST     4
`define RTW_CTRL_RESET     5'h18
`endif

// ### rtw_core.v
// What this block does
// - reset command: status first, then reset
// - while resetting answer busy status only
// - reset completes within five milliseconds
// - self test: status first, then test
// - while testing answer busy status only
// - self test done within hundred milliseconds
// - status word always holds valid content
// - message error kept, instrumentation/reserved zero
// - broadcast received bit; no bus control
// - terminal and subsystem flag bits kept
// - busy conditions shown in busy bit
// - busy only from commands or faults
// - broadcast told apart from addressed messages
// - address 11111 only for broadcast
// - wrap subaddress receives and returns N words
// - wrap transmit returns received words exactly
// - subaddress 30 is the wrap subaddress
// - basic message formats supported, but mode codes only without a data word
// - same data path for both transfer kinds
// - late first data word invalidates message
// - status, shutdown, override, reset codes kept
// - mode subaddress 00000 and 11111 equal
// - bad wired address keeps terminal silent
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "rtw_defines.vh"
module rtw_core #(
   parameter MAX_WC   = 32,
   parameter RST_US   = `RTW_RST_US,
   parameter ST_US    = `RTW_ST_US,
   parameter RTRT_CYC = `RTW_RTRT_CYC
) (
   input  wire        core_clk_in,
   input  wire        rst_b_in,
   input  wire [4:0]  rt_addr_in,
   input  wire        rt_addr_par_in,
   input  wire        rx_valid_in,
   input  wire [15:0] rx_word_in,
   input  wire        rx_cmd_in,
   input  wire        rx_err_in,
   input  wire        rx_bus_in,
   input  wire        rx_dsync_in,
   input  wire        tx_ready_in,
   input  wire        tx_done_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   output reg         pready_out,
   output reg  [31:0] prdata_out,
   output reg         pslverr_out,
   output reg         tx_valid_out,
   output reg  [15:0] tx_word_out,
   output reg         tx_cmd_sync_out,
   output reg         tx_bus_out,
   output reg  [1:0]  tx_inhibit_out,
   output reg         rx_data_valid_out,
   output reg  [15:0] rx_data_out,
   output reg  [4:0]  rx_sa_out,
   output reg         rx_bcast_out
);
   localparam S_IDLE = 2'd0;
   localparam S_RX   = 2'd1;
   localparam S_STAT = 2'd2;
   localparam S_DATA = 2'd3;
   localparam A_NONE = 2'd0;
   localparam A_RST  = 2'd1;
   localparam A_TEST = 2'd2;

   reg  [1:0]  state_reg;
   reg  [15:0] mem_reg [0:MAX_WC-1];
   reg  [5:0]  idx_reg;
   reg  [5:0]  wc_reg;
   reg  [4:0]  sa_reg;
   reg         bc_reg;
   reg         nodata_reg;
   reg         first_reg;
   reg  [31:0] rtrt_cnt_reg;
   reg  [7:0]  div_reg;
   reg         tick_reg;
   reg  [1:0]  act_reg;
   reg  [1:0]  pend_reg;
   reg  [16:0] act_cnt_reg;
   reg  [4:0]  addr_reg;
   reg         addr_ok_reg;
   reg         strap_done_reg;
   reg         me_reg;
   reg         bcr_reg;
   reg         tf_reg;
   reg         test_done_reg;
   reg  [4:0]  ctrl_reg;
   reg  [15:0] last_cmd_reg;
   reg  [15:0] last_stat_reg;
   reg  [31:0] rdata_next;
   reg         err_next;

   wire [4:0]  c_addr = rx_word_in[`RTW_CMD_ADDR_HI:`RTW_CMD_ADDR_LO];
   wire        c_tr   = rx_word_in[`RTW_CMD_TR];
   wire [4:0]  c_sa   = rx_word_in[`RTW_CMD_SA_HI:`RTW_CMD_SA_LO];
   wire [4:0]  c_wc   = rx_word_in[`RTW_CMD_WC_HI:`RTW_CMD_WC_LO];
   wire        bc_en  = ctrl_reg[`RTW_CTRL_BCAST];
   wire        c_bc   = bc_en && (c_addr == `RTW_BCAST_ADDR);
   wire        c_me   = addr_ok_reg && (c_addr == addr_reg);
   wire        c_take = rx_valid_in && rx_cmd_in && !rx_err_in && (c_me || c_bc);
   wire        c_mode = (c_sa == `RTW_MODE_SA0) || (c_sa == `RTW_MODE_SA1);
   wire        busy   = (act_reg != A_NONE) || ctrl_reg[`RTW_CTRL_FAULT];
   wire        d_take = rx_valid_in && !rx_cmd_in;

   // zero word count encodes the full 32
   function [5:0] rtw_wc;
      input [4:0] wc;
      begin
         rtw_wc = (wc == 5'h00) ? 6'd32 : {1'b0, wc};
      end
   endfunction

   // status bits, reserved and instrumentation zero
   function [15:0] rtw_status;
      input [4:0] a;
      input       me;
      input       bcr;
      input       bsy;
      input [4:0] ctl;
      input       tf;
      begin
         rtw_status = 16'h0000;
         rtw_status[15:11] = a;
         rtw_status[`RTW_ST_ME] = me;
         rtw_status[`RTW_ST_SR] = ctl[`RTW_CTRL_SR];
         rtw_status[`RTW_ST_BCR] = bcr;
         rtw_status[`RTW_ST_BUSY] = bsy;
         rtw_status[`RTW_ST_SSF] = ctl[`RTW_CTRL_SSF];
         rtw_status[`RTW_ST_TF] = tf | ctl[`RTW_CTRL_FAULT];
      end
   endfunction

   // microsecond enable for the long activity timers
   always @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         div_reg <= 8'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= (div_reg == 8'd`RTW_CLK_MHZ - 8'd1);
         div_reg <= (div_reg == 8'd`RTW_CLK_MHZ - 8'd1) ? 8'h00 : div_reg + 8'd1;
      end
   end

   // straps caught one edge after reset release
   always @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         strap_done_reg <= 1'b0;
         addr_reg <= 5'h00;
         addr_ok_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         strap_done_reg <= 1'b1;
         addr_reg <= rt_addr_in;
         // odd parity and no broadcast address
         addr_ok_reg <= (^{rt_addr_in, rt_addr_par_in}) && (rt_addr_in != `RTW_BCAST_ADDR);
      end
   end

   // APB decode
   always @*
   begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      if (paddr_in == `RTW_REG_CTRL)
         rdata_next = {27'h0, ctrl_reg};
      else if (paddr_in == `RTW_REG_STAT)
         rdata_next = {last_stat_reg, 2'h0, tf_reg, test_done_reg, act_reg,
                       tx_inhibit_out, addr_ok_reg, addr_reg, state_reg};
      else if (paddr_in == `RTW_REG_LASTCMD)
         rdata_next = {16'h0, last_cmd_reg};
      else
         err_next = 1'b1;
   end

   always @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         pready_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
         ctrl_reg <= `RTW_CTRL_RESET;
      end
      else
      begin
         // one wait-free access phase after each setup
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && err_next;
         if (psel_in && !penable_in)
            prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_next;
         if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == `RTW_REG_CTRL)
            ctrl_reg <= pwdata_in[4:0];
      end
   end

   // wrap-around storage, one word per index
   genvar gi;
   generate
      for (gi = 0; gi < MAX_WC; gi = gi + 1)
      begin : g_mem
         always @(posedge core_clk_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
               mem_reg[gi] <= 16'h0000;
            else if (state_reg == S_RX && d_take && !rx_err_in && idx_reg == gi
                     && sa_reg == `RTW_WRAP_SA)
               mem_reg[gi] <= rx_word_in;
         end
      end
   endgenerate

   always @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_reg <= S_IDLE;
         idx_reg <= 6'd0;
         wc_reg <= 6'd0;
         sa_reg <= 5'h00;
         bc_reg <= 1'b0;
         nodata_reg <= 1'b0;
         first_reg <= 1'b0;
         rtrt_cnt_reg <= 32'd0;
         act_reg <= A_NONE;
         pend_reg <= A_NONE;
         act_cnt_reg <= 17'd0;
         me_reg <= 1'b0;
         bcr_reg <= 1'b0;
         tf_reg <= 1'b0;
         test_done_reg <= 1'b0;
         last_cmd_reg <= 16'h0000;
         last_stat_reg <= 16'h0000;
         tx_valid_out <= 1'b0;
         tx_word_out <= 16'h0000;
         tx_cmd_sync_out <= 1'b0;
         tx_bus_out <= 1'b0;
         tx_inhibit_out <= 2'b00;
         rx_data_valid_out <= 1'b0;
         rx_data_out <= 16'h0000;
         rx_sa_out <= 5'h00;
         rx_bcast_out <= 1'b0;
      end
      else
      begin
         rx_data_valid_out <= 1'b0;
         // activity starts once status parity is out
         if (tx_done_in && pend_reg != A_NONE && state_reg == S_IDLE)
         begin
            act_reg <= pend_reg;
            pend_reg <= A_NONE;
            act_cnt_reg <= 17'd0;
            if (pend_reg == A_RST)
            begin
               tx_inhibit_out <= 2'b00;
               me_reg <= 1'b0;
               bcr_reg <= 1'b0;
            end
            else
               test_done_reg <= 1'b0;
         end
         else if (act_reg != A_NONE && tick_reg)
         begin
            if (act_reg == A_RST && act_cnt_reg == RST_US - 1)
               act_reg <= A_NONE;
            // self test result ready inside limit
            else if (act_reg == A_TEST && act_cnt_reg == ST_US - 1)
            begin
               act_reg <= A_NONE;
               test_done_reg <= 1'b1;
               tf_reg <= ctrl_reg[`RTW_CTRL_FAULT];
            end
            else
               act_cnt_reg <= act_cnt_reg + 17'd1;
         end
         case (state_reg)
            S_IDLE, S_RX:
            begin
               if (state_reg == S_RX && !first_reg)
               begin
                  rtrt_cnt_reg <= rtrt_cnt_reg + 32'd1;
                  if (rx_dsync_in)
                     first_reg <= 1'b1;
               end
               if (c_take)
               begin
                  last_cmd_reg <= rx_word_in;
                  tx_bus_out <= rx_bus_in;
                  sa_reg <= c_sa;
                  bc_reg <= c_bc;
                  wc_reg <= rtw_wc(c_wc);
                  idx_reg <= 6'd0;
                  if (!(c_mode && c_wc == `RTW_MC_TX_STATUS))
                  begin
                     me_reg <= 1'b0;
                     bcr_reg <= c_bc;
                  end
                  if (c_mode)
                  begin
                     if (c_wc == `RTW_MC_SHUTDOWN)
                        tx_inhibit_out[~rx_bus_in] <= 1'b1;
                     if (c_wc == `RTW_MC_OVERRIDE)
                        tx_inhibit_out[~rx_bus_in] <= 1'b0;
                     if (c_wc == `RTW_MC_RESET && !c_bc)
                        pend_reg <= A_RST;
                     // self test follows the status word
                     if (c_wc == `RTW_MC_SELF_TEST && !c_bc && ctrl_reg[`RTW_CTRL_STEST])
                        pend_reg <= A_TEST;
                     nodata_reg <= 1'b1;
                     state_reg <= c_bc ? S_IDLE : S_STAT;
                  end
                  else if (!c_tr)
                  begin
                     rtrt_cnt_reg <= 32'd0;
                     first_reg <= 1'b0;
                     state_reg <= S_RX;
                  end
                  else
                  begin
                     nodata_reg <= busy;
                     state_reg <= c_bc ? S_IDLE : S_STAT;
                  end
               end
               else if (state_reg == S_RX && !first_reg && RTRT_CYC <= rtrt_cnt_reg)
               begin
                  me_reg <= 1'b1;
                  state_reg <= S_IDLE;
               end
               else if (state_reg == S_RX && d_take)
               begin
                  if (rx_err_in)
                  begin
                     me_reg <= 1'b1;
                     state_reg <= S_IDLE;
                  end
                  else
                  begin
                     // one path for both receive kinds
                     rx_data_valid_out <= 1'b1;
                     rx_data_out <= rx_word_in;
                     rx_sa_out <= sa_reg;
                     rx_bcast_out <= bc_reg;
                     idx_reg <= idx_reg + 6'd1;
                     if (idx_reg + 6'd1 == wc_reg)
                     begin
                        nodata_reg <= 1'b1;
                        state_reg <= bc_reg ? S_IDLE : S_STAT;
                     end
                  end
               end
            end
            S_STAT:
            begin
               if (!tx_valid_out)
               begin
                  tx_valid_out <= 1'b1;
                  tx_cmd_sync_out <= 1'b1;
                  // live status word
                  // tx-status leaves me and bcr alone, so a live word is valid even after power up
                  tx_word_out <= rtw_status(addr_reg, me_reg, bcr_reg, busy, ctrl_reg, tf_reg);
                  last_stat_reg <= rtw_status(addr_reg, me_reg, bcr_reg, busy, ctrl_reg, tf_reg);
               end
               else if (tx_ready_in)
               begin
                  tx_valid_out <= 1'b0;
                  idx_reg <= 6'd0;
                  state_reg <= nodata_reg ? S_IDLE : S_DATA;
               end
            end
            S_DATA:
            begin
               if (!tx_valid_out)
               begin
                  tx_valid_out <= 1'b1;
                  tx_cmd_sync_out <= 1'b0;
                  tx_word_out <= mem_reg[idx_reg[4:0]];
               end
               else if (tx_ready_in)
               begin
                  tx_valid_out <= 1'b0;
                  idx_reg <= idx_reg + 6'd1;
                  if (idx_reg + 6'd1 == wc_reg)
                     state_reg <= S_IDLE;
               end
            end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end
endmodule

// ### rtw_checker.sv
`timescale 1ns/1ps
module rtw_checker (
   input logic        core_clk_in,
   input logic        rst_b_in,
   input logic [4:0]  rt_addr_in,
   input logic        rt_addr_par_in,
   input logic        rx_valid_in,
   input logic [15:0] rx_word_in,
   input logic        rx_cmd_in,
   input logic        rx_err_in,
   input logic        tx_ready_in,
   input logic        psel_in,
   input logic        penable_in,
   input logic [11:0] paddr_in,
   input logic        pready_out,
   input logic        pslverr_out,
   input logic        tx_valid_out,
   input logic [15:0] tx_word_out,
   input logic        tx_cmd_sync_out
);
   default clocking dc @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   wire addr_ok = (^{rt_addr_in, rt_addr_par_in}) && rt_addr_in != 5'h1F;
   wire stat_tx = tx_valid_out && tx_cmd_sync_out;
   wire own_tx  = rx_valid_in && rx_cmd_in && !rx_err_in && rx_word_in[10] && rx_word_in[15:11] == rt_addr_in && addr_ok;
   AST_STAT_ZERO_BITS: assert property (stat_tx |-> !tx_word_out[9] && tx_word_out[7:5] == 3'h0)
      else $error("status word has instrumentation or reserved bit set");
   AST_DBC_ZERO: assert property (stat_tx |-> !tx_word_out[1])
      else $error("status word claims bus control acceptance");
   AST_STAT_ADDR: assert property (stat_tx |-> tx_word_out[15:11] == rt_addr_in)
      else $error("status word carries a wrong address");
   AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_word_out))
      else $error("transmit word dropped or changed before taken");
   AST_STATUS_FIRST: assert property (own_tx && !tx_valid_out |-> ##[1:3] stat_tx)
      else $error("no status word after a transmit command");
   AST_BAD_ADDR_SILENT: assert property (rx_valid_in && rx_cmd_in && !addr_ok |=> !tx_valid_out [*4])
      else $error("terminal answered with an invalid address");
   AST_BCAST_SILENT: assert property (rx_valid_in && rx_cmd_in && rx_word_in[15:11] == 5'h1F && !tx_valid_out
                                      |=> !tx_valid_out [*4])
      else $error("terminal answered a broadcast command");
   AST_APB_ANSWER: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
      else $error("apb ready not exactly one cycle after setup");
   AST_APB_ERR: assert property (psel_in && !penable_in |=> pslverr_out == ($past(paddr_in) != 12'h000
                                 && $past(paddr_in) != 12'h004 && $past(paddr_in) != 12'h008))
      else $error("apb error response does not match the address map");
endmodule
bind rtw_core rtw_checker i_chk (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .rt_addr_in(rt_addr_in), .rt_addr_par_in(rt_addr_par_in),
   .rx_valid_in(rx_valid_in), .rx_word_in(rx_word_in), .rx_cmd_in(rx_cmd_in), .rx_err_in(rx_err_in),
   .tx_ready_in(tx_ready_in), .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .tx_valid_out(tx_valid_out),
   .tx_word_out(tx_word_out), .tx_cmd_sync_out(tx_cmd_sync_out)
);

// ### rtw_bc_model.sv
`timescale 1ns/1ps
module rtw_bc_model (
   input  logic        clk_in,
   input  logic        tx_valid_in,
   input  logic [15:0] tx_word_in,
   input  logic        tx_sync_in,
   output logic        rx_valid_out,
   output logic [15:0] rx_word_out,
   output logic        rx_cmd_out,
   output logic        rx_err_out,
   output logic        rx_dsync_out,
   output logic        tx_ready_out,
   output logic        tx_done_out
);
   // encoder stall before accepting, to exercise held words
   int stall = 0;
   initial
   begin
      {rx_valid_out, rx_cmd_out, rx_err_out, rx_dsync_out, tx_ready_out, tx_done_out} = 6'h00;
      rx_word_out = 16'h0000;
   end
   task automatic put(input logic cmd, input logic [15:0] w, input logic err);
      rx_valid_out <= 1'b1;
      rx_word_out  <= w;
      rx_cmd_out   <= cmd;
      rx_err_out   <= err;
      rx_dsync_out <= !cmd;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_dsync_out <= 1'b0;
      // stale word inverted so nothing reads a leftover value
      rx_word_out  <= ~w;
      @(posedge clk_in);
   endtask
   task automatic take(output logic [15:0] w, output logic s, output bit ok);
      int n;
      n = 0;
      while (tx_valid_in !== 1'b1 && n < 300)
      begin
         @(posedge clk_in);
         n++;
      end
      repeat (stall) @(posedge clk_in);
      tx_ready_out <= 1'b1;
      @(posedge clk_in);
      w  = tx_word_in;
      s  = tx_sync_in;
      ok = n < 300 && tx_valid_in === 1'b1;
      tx_ready_out <= 1'b0;
      @(posedge clk_in);
      tx_done_out <= 1'b1;
      @(posedge clk_in);
      tx_done_out <= 1'b0;
   endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
   typedef struct packed {logic [15:0] cmd; logic [15:0] st; logic [1:0] inh;} rtw_row_t;
   localparam int          RST_US = 5;
   localparam int          ST_US  = 10;
   localparam int          RTRT   = 50;
   localparam logic [15:0] ST_OK  = 16'h2800;
   logic        core_clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic [4:0]  rt_addr_in = 5'h05;
   logic        rt_addr_par_in = 1'b1;
   logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   logic        rx_valid_in, rx_cmd_in, rx_err_in, rx_dsync_in, tx_ready_in, tx_done_in;
   logic        pready_out, pslverr_out, tx_valid_out, tx_cmd_sync_out, tx_bus_out, rx_data_valid_out, rx_bcast_out;
   logic [15:0] rx_word_in, tx_word_out, rx_data_out, w;
   logic [1:0]  tx_inhibit_out;
   logic [4:0]  rx_sa_out;
   logic        s, pe;
   logic        rx_bus_in = 1'b0;
   bit          ok;
   int          err_count = 0;
   int          tests_run = 0;
   int          ndv = 0;
   rtw_row_t    rows [4] = '{'{16'h2C02, ST_OK, 2'b00}, '{16'h2FE4, ST_OK, 2'b10},
                             '{16'h2C05, ST_OK, 2'b00}, '{16'h2FE2, ST_OK, 2'b00}};
   always #2.5 core_clk_in = ~core_clk_in;
   rtw_core #(.MAX_WC(32), .RST_US(RST_US), .ST_US(ST_US), .RTRT_CYC(RTRT)) i_dut (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .rt_addr_in(rt_addr_in), .rt_addr_par_in(rt_addr_par_in),
      .rx_valid_in(rx_valid_in), .rx_word_in(rx_word_in), .rx_cmd_in(rx_cmd_in), .rx_err_in(rx_err_in),
      .rx_bus_in(rx_bus_in), .rx_dsync_in(rx_dsync_in), .tx_ready_in(tx_ready_in), .tx_done_in(tx_done_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
      .tx_valid_out(tx_valid_out), .tx_word_out(tx_word_out), .tx_cmd_sync_out(tx_cmd_sync_out),
      .tx_bus_out(tx_bus_out), .tx_inhibit_out(tx_inhibit_out), .rx_data_valid_out(rx_data_valid_out),
      .rx_data_out(rx_data_out), .rx_sa_out(rx_sa_out), .rx_bcast_out(rx_bcast_out));
   rtw_bc_model i_bc (
      .clk_in(core_clk_in), .tx_valid_in(tx_valid_out), .tx_word_in(tx_word_out), .tx_sync_in(tx_cmd_sync_out),
      .rx_valid_out(rx_valid_in), .rx_word_out(rx_word_in), .rx_cmd_out(rx_cmd_in), .rx_err_out(rx_err_in),
      .rx_dsync_out(rx_dsync_in), .tx_ready_out(tx_ready_in), .tx_done_out(tx_done_in));
   always @(posedge core_clk_in)
      if (rx_data_valid_out === 1'b1)
         ndv <= ndv + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel_in   <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in  <= a;
      pwdata_in <= wd;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do
         @(posedge core_clk_in);
      while (pready_out !== 1'b1);
      chk({31'h0, pready_out}, 32'h1);
      rd = prdata_out;
      pe = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic resp(input logic [15:0] e, input logic es);
      i_bc.take(w, s, ok);
      chk({14'h0, ok, s, w}, {14'h0, 1'b1, es, e});
   endtask
   task automatic quiet(input int n);
      repeat (n)
      begin
         @(posedge core_clk_in);
         chk({31'h0, tx_valid_out}, 32'h0);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      err_count++;
      wrap_up();
   end
   initial
   begin
      repeat (8) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h18);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b0, 12'h004, 32'h0);
      chk({26'h0, rd[7:2]}, 32'h25);
      apb(1'b0, 12'h00C, 32'h0);
      chk({pe, rd[30:0]}, 32'h80000000);
      foreach (rows[i])
      begin
         i_bc.put(1'b1, rows[i].cmd, 1'b0);
         resp(rows[i].st, 1'b1);
         repeat (2) @(posedge core_clk_in);
         chk({30'h0, tx_inhibit_out}, {30'h0, rows[i].inh});
      end
      // shutdown and override arriving on the second bus
      rx_bus_in <= 1'b1;
      i_bc.put(1'b1, 16'h2C04, 1'b0);
      resp(ST_OK, 1'b1);
      chk({29'h0, tx_bus_out, tx_inhibit_out}, 32'h5);
      i_bc.put(1'b1, 16'h2C05, 1'b0);
      resp(ST_OK, 1'b1);
      chk({29'h0, tx_bus_out, tx_inhibit_out}, 32'h4);
      rx_bus_in <= 1'b0;
      // full-count wrap-around with a stalling encoder
      i_bc.stall = 3;
      i_bc.put(1'b1, 16'h2BC0, 1'b0);
      for (int i = 0; i < 32; i++)
         i_bc.put(1'b0, 16'hA5C3 ^ {i[7:0], i[7:0]}, 1'b0);
      resp(ST_OK, 1'b1);
      chk(ndv, 32);
      chk({10'h0, rx_bcast_out, rx_sa_out, rx_data_out}, {10'h0, 1'b0, 5'h1E, 16'hBADC});
      i_bc.put(1'b1, 16'h2FC0, 1'b0);
      resp(ST_OK, 1'b1);
      for (int i = 0; i < 32; i++)
         resp(16'hA5C3 ^ {i[7:0], i[7:0]}, 1'b0);
      i_bc.stall = 0;
      // first data word too late
      i_bc.put(1'b1, 16'h2BC1, 1'b0);
      repeat (RTRT + 10) @(posedge core_clk_in);
      i_bc.put(1'b0, 16'h1234, 1'b0);
      quiet(20);
      i_bc.put(1'b1, 16'h2C02, 1'b0);
      resp(16'h2C00, 1'b1);
      i_bc.put(1'b1, 16'hFC05, 1'b0);
      quiet(10);
      i_bc.put(1'b1, 16'hF821, 1'b0);
      i_bc.put(1'b0, 16'h1357, 1'b0);
      quiet(6);
      chk({10'h0, rx_bcast_out, rx_sa_out, rx_data_out}, {10'h0, 1'b1, 5'h01, 16'h1357});
      i_bc.put(1'b1, 16'h2C02, 1'b0);
      resp(16'h2810, 1'b1);
      apb(1'b1, 12'h000, 32'h1B);
      i_bc.put(1'b1, 16'h2C05, 1'b0);
      resp(16'h2904, 1'b1);
      apb(1'b1, 12'h000, 32'h1C);
      i_bc.put(1'b1, 16'h2C05, 1'b0);
      resp(16'h2809, 1'b1);
      apb(1'b1, 12'h000, 32'h18);
      // reset then self test: status first, busy meanwhile, clear after the bound
      for (int k = 0; k < 2; k++)
      begin
         i_bc.put(1'b1, k ? 16'h2C03 : 16'h2C08, 1'b0);
         resp(ST_OK, 1'b1);
         i_bc.put(1'b1, 16'h2C05, 1'b0);
         resp(16'h2808, 1'b1);
         repeat ((k ? ST_US : RST_US) * 200) @(posedge core_clk_in);
         i_bc.put(1'b1, 16'h2C05, 1'b0);
         resp(ST_OK, 1'b1);
      end
      apb(1'b0, 12'h004, 32'h0);
      chk({30'h0, rd[13:12]}, 32'h1);
      // second reset with a strap of bad parity
      rst_b_in       <= 1'b0;
      rt_addr_in     <= 5'h06;
      rt_addr_par_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      i_bc.put(1'b1, 16'h3405, 1'b0);
      quiet(10);
      apb(1'b0, 12'h004, 32'h0);
      chk({31'h0, rd[7]}, 32'h0);
      wrap_up();
   end
endmodule
